// >>> verification/bus_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus controller model
module bus_host (
  input wire clk_i,
  input wire ndac_oe_n_i,
  input wire dav_oe_n_i,
  input wire [7:0] dio_line_i,
  output logic atn_o,
  output logic ren_o,
  output logic ifc_o,
  output logic dav_o,
  output logic nrfd_o,
  output logic ndac_o,
  output logic [7:0] dio_o
);
  initial {atn_o, ren_o, ifc_o, dav_o, nrfd_o, ndac_o, dio_o} = '0;
  task automatic msg(input logic [7:0] b);
    int n;
    n = 0;
    atn_o <= 1'b1;
    dio_o <= b;
    dav_o <= 1'b1;
    do @(posedge clk_i); while (ndac_oe_n_i !== 1'b1 && ++n < 30);
    dav_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic clear_bus();
    ifc_o <= 1'b1;
    repeat (2500) @(posedge clk_i);
    ifc_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic take_byte(output logic [7:0] sb);
    int n;
    n = 0;
    ndac_o <= 1'b1;
    nrfd_o <= 1'b1;
    dio_o <= 8'h00;
    atn_o <= 1'b0;
    @(posedge clk_i);
    nrfd_o <= 1'b0;
    do @(posedge clk_i); while (dav_oe_n_i !== 1'b0 && ++n < 30);
    sb = dio_line_i;
    ndac_o <= 1'b0;
    nrfd_o <= 1'b1;
    do @(posedge clk_i); while (dav_oe_n_i !== 1'b1 && ++n < 60);
    nrfd_o <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] ta, output logic [7:0] sb);
    msg(8'h18);
    msg(ta);
    take_byte(sb);
    msg(8'h19);
  endtask
endmodule
`default_nettype wire

// >>> verification/ieee488_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module ieee488_props #(
  parameter NKEY = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire atn_i,
  input wire ren_i,
  input wire ifc_i,
  input wire dio_oe_n_o,
  input wire [NKEY-1:0] keys_o,
  input wire remote_o,
  input wire [4:0] addr_disp_o,
  input wire show_addr_o,
  input wire trigger_o,
  input wire dev_clear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_keys; remote_o |-> keys_o == '0; endproperty
  a_keys: assert property (p_keys) else $error("keys live");
  property p_ren; $rose(remote_o) |-> $past(ren_i); endproperty
  a_ren: assert property (p_ren) else $error("remote no ren");
  property p_ifc; ifc_i [*3] |-> !remote_o && dio_oe_n_o; endproperty
  a_ifc: assert property (p_ifc) else $error("ifc ignored");
  property p_trg; trigger_o |=> !trigger_o; endproperty
  a_trg: assert property (p_trg) else $error("long trigger");
  property p_clr; dev_clear_o |=> !dev_clear_o; endproperty
  a_clr: assert property (p_clr) else $error("long clear");
  property p_get; trigger_o |-> $past(atn_i) && !$past(ifc_i); endproperty
  a_get: assert property (p_get) else $error("stray trigger");
  property p_addr; addr_disp_o <= 5'h1e; endproperty
  a_addr: assert property (p_addr) else $error("addr range");
  property p_rst;
    $fell(rst_i) |-> !remote_o && show_addr_o && addr_disp_o == 5'h10;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  cover property (trigger_o);
  cover property (dev_clear_o);
  cover property ($rose(remote_o));
endmodule

bind ieee488_device_interface ieee488_props #(.NKEY(NKEY)) u_props (
  .clk_i, .rst_i, .atn_i, .ren_i, .ifc_i, .dio_oe_n_o, .keys_o,
  .remote_o, .addr_disp_o, .show_addr_o, .trigger_o, .dev_clear_o
);
`default_nettype wire

// >>> verification/test_ieee488_device_interface.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Testbench
module test_ieee488_device_interface;
  logic clk_i = '0, rst_i = 1'b1, avs_read_i = '0, avs_write_i = '0;
  logic [3:0] avs_address_i = '0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, rd;
  logic avs_waitrequest_o, dio_oe_n_o, dav_o, dav_oe_n_o, nrfd_o;
  logic nrfd_oe_n_o, ndac_o, ndac_oe_n_o, srq_o, srq_oe_n_o, remote_o;
  logic show_addr_o, rx_valid_o, tx_ready_o, trigger_o, dev_clear_o;
  logic local_key_i = '0, tx_valid_i = '0, atn_i, ren_i, ifc_i;
  logic p_dav, p_nrfd, p_ndac;
  logic [7:0] dio_o, keys_i = '0, keys_o, rx_data_o, tx_data_i = '0;
  logic [7:0] sb, p_dio;
  logic [4:0] addr_disp_o;
  int fail_count = 0, checks = 0, trig_n = 0, clr_n = 0;
  wire [7:0] dio_i = p_dio | (dio_oe_n_o ? 8'h00 : dio_o);
  wire dav_i = p_dav | ~dav_oe_n_o;
  wire nrfd_i = p_nrfd | ~nrfd_oe_n_o;
  wire ndac_i = p_ndac | ~ndac_oe_n_o;
  ieee488_device_interface #(.NKEY(8)) dut (.*);
  bus_host ctl (.clk_i(clk_i), .ndac_oe_n_i(ndac_oe_n_o),
    .dav_oe_n_i(dav_oe_n_o), .dio_line_i(dio_i), .atn_o(atn_i),
    .ren_o(ren_i), .ifc_o(ifc_i), .dav_o(p_dav), .nrfd_o(p_nrfd),
    .ndac_o(p_ndac), .dio_o(p_dio));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (trigger_o === 1'b1) trig_n++;
  always @(posedge clk_i) if (dev_clear_o === 1'b1) clr_n++;
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic press();
    local_key_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    local_key_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("disp", 5'h10, addr_disp_o);
    chk("show", 1'b1, show_addr_o);
    acc(1'b0, 4'h0, 8'h00);
    chk("addr", 32'h10, rd);
    acc(1'b0, 4'h4, 8'h00);
    chk("stat", 32'h0, rd);
    $display("test reset done");
    acc(1'b1, 4'h0, 8'h1f);
    acc(1'b0, 4'h0, 8'h00);
    chk("addr", 32'h10, rd);
    acc(1'b0, 4'h4, 8'h00);
    chk("aerr", 1'b1, rd[5]);
    acc(1'b1, 4'h0, 8'h1e);
    acc(1'b0, 4'h0, 8'h00);
    chk("addr", 32'h1e, rd);
    acc(1'b1, 4'hc, 8'h01);
    acc(1'b0, 4'h0, 8'h00);
    chk("addr", 32'h10, rd);
    acc(1'b0, 4'h2, 8'h00);
    chk("unmap", 32'h0, rd);
    acc(1'b1, 4'h0, 8'h05);
    avs_byteenable_i <= 4'he;
    acc(1'b1, 4'h0, 8'h07);
    avs_byteenable_i <= 4'hf;
    acc(1'b0, 4'h0, 8'h00);
    chk("be", 32'h05, rd);
    $display("test address done");
    ctl.ren_o <= 1'b1;
    ctl.msg(8'h30);
    chk("rem", 1'b0, remote_o);
    ctl.msg(8'h25);
    chk("rem", 1'b1, remote_o);
    keys_i <= 8'h5a;
    @(posedge clk_i);
    chk("keys", 8'h00, keys_o);
    press();
    chk("rem", 1'b0, remote_o);
    chk("keys", 8'h5a, keys_o);
    $display("test remote done");
    ctl.msg(8'h25);
    ctl.msg(8'h11);
    press();
    chk("rem", 1'b1, remote_o);
    ctl.msg(8'h01);
    chk("rem", 1'b0, remote_o);
    acc(1'b0, 4'h4, 8'h00);
    chk("llo", 1'b0, rd[1]);
    $display("test lockout done");
    ctl.msg(8'h08);
    chk("trig", 1, trig_n);
    ctl.msg(8'h3f);
    ctl.msg(8'h08);
    ctl.msg(8'h04);
    chk("trig", 1, trig_n);
    chk("clr", 0, clr_n);
    ctl.msg(8'h14);
    chk("clr", 1, clr_n);
    ctl.msg(8'h25);
    ctl.msg(8'h04);
    chk("clr", 2, clr_n);
    $display("test events done");
    acc(1'b1, 4'h8, 8'h41);
    chk("srq", 1'b0, srq_oe_n_o);
    ctl.poll(8'h45, sb);
    chk("stb", 8'h41, sb);
    ctl.poll(8'h45, sb);
    chk("stb", 8'h01, sb);
    $display("test poll done");
    ctl.msg(8'h45);
    tx_data_i <= 8'ha5;
    tx_valid_i <= 1'b1;
    fork
      ctl.take_byte(sb);
      begin
        do @(posedge clk_i); while (tx_ready_o !== 1'b1);
        tx_valid_i <= 1'b0;
      end
    join
    chk("tx", 8'ha5, sb);
    chk("rx", 8'ha5, rx_data_o);
    $display("test talk done");
    ctl.msg(8'h25);
    ctl.clear_bus();
    chk("rem", 1'b0, remote_o);
    acc(1'b0, 4'h4, 8'h00);
    chk("idle", 2'b00, rd[3:2]);
    acc(1'b0, 4'h0, 8'h00);
    chk("addr", 32'h05, rd);
    $display("test ifc done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> verilog/gpib_if_map.vh
`ifndef GPIB_IF_MAP_VH
`define GPIB_IF_MAP_VH

// ==========================================
// Register byte offsets
`define OFS_ADDR 4'h0
`define OFS_STAT 4'h4
`define OFS_STB 4'h8
`define OFS_CTRL 4'hc

// ==========================================
// Reset values and limits
`define ADDR_FACTORY 5'h10
`define ADDR_MAX 5'h1e
`define STB_RST 8'h00

// ==========================================
// Field positions
`define STAT_REM 0
`define STAT_LLO 1
`define STAT_LISTEN 2
`define STAT_TALK 3
`define STAT_POLL 4
`define STAT_ADDR_ERR 5
`define STAT_SRQ 6
`define STB_RSV 6
`define CTRL_DEFAULT 0

// ==========================================
// Bus messages sent with attention true
`define MSG_GTL 7'h01
`define MSG_SDC 7'h04
`define MSG_GET 7'h08
`define MSG_LLO 7'h11
`define MSG_DCL 7'h14
`define MSG_SPE 7'h18
`define MSG_SPD 7'h19
`define MSG_UNL 7'h3f
`define MSG_UNT 7'h5f
`define GRP_LISTEN 2'b01
`define GRP_TALK 2'b10

// ==========================================
// Source handshake states
`define SRC_IDLE 2'h0
`define SRC_WAIT 2'h1
`define SRC_DAV 2'h2
`define SRC_HOLD 2'h3

`endif

// >>> verilog/ieee488_device_interface.v
// Overview of operation
// - Factory default restore sets address 16; only that address is answered.
// - Address writes above 30 are rejected and leave the address unchanged.
// - Remote is entered only when addressed to listen while remote enable true.
// - Talking works whenever addressed to talk, in remote or local.
// - In remote every front-panel key except local is ignored.
// - Local key in remote without lockout returns to local, keys enabled.
// - Interface clear forces local, talker idle and listener idle.
// - Interface clear leaves settings, stored data and registers untouched.
// - After lockout all keys are ignored, the local key included.
// - Go-to-local and power-up both cancel lockout.
// - Go-to-local while listening and in remote returns to local.
// - Universal device clear acts whether addressed or not.
// - Device clear pulses a flush of buffers and queues; settings kept.
// - Selective clear acts like device clear, only while listening.
// - Trigger while listening gives exactly one trigger pulse.
// - Serial poll returns the status byte at any time.
// - Service request is asserted; the controller polls to find it.
// - Remote indicator is on in remote and off in local.
// - The primary address is presented on the display from power-up.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gpib_if_map.vh"

module ieee488_device_interface #(
  parameter NKEY = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire [7:0] dio_i,
  output reg [7:0] dio_o,
  output wire dio_oe_n_o,
  input wire atn_i,
  input wire ren_i,
  input wire ifc_i,
  input wire dav_i,
  output wire dav_o,
  output wire dav_oe_n_o,
  input wire nrfd_i,
  output wire nrfd_o,
  output wire nrfd_oe_n_o,
  input wire ndac_i,
  output wire ndac_o,
  output wire ndac_oe_n_o,
  output wire srq_o,
  output wire srq_oe_n_o,
  input wire [NKEY-1:0] keys_i,
  input wire local_key_i,
  output wire [NKEY-1:0] keys_o,
  output wire remote_o,
  output wire [4:0] addr_disp_o,
  output wire show_addr_o,
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output wire tx_ready_o,
  output reg trigger_o,
  output reg dev_clear_o
);

  // ==========================================
  // State
  reg ack_q;
  reg [4:0] addr_q;
  reg addr_err_q;
  reg [7:0] stb_q;
  reg rem_q;
  reg llo_q;
  reg listen_q;
  reg talk_q;
  reg poll_q;
  reg hold_q;
  reg polled_q;
  reg lkey_q;
  reg show_q;
  reg [1:0] src_q;
  reg poll_byte_q;

  // ==========================================
  // Register bus slave, one wait cycle
  wire req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ack_q & avs_byteenable_i[0];
  wire rd_go = avs_read_i & ack_q;
  wire addr_wr = wr_go & (avs_address_i == `OFS_ADDR);
  wire addr_ok = avs_writedata_i[7:0] <= {3'h0, `ADDR_MAX};
  wire dflt_wr = wr_go & (avs_address_i == `OFS_CTRL) &
                 avs_writedata_i[`CTRL_DEFAULT];
  wire rsv = stb_q[`STB_RSV];
  wire srq_on = rsv & ~polled_q;
  wire [7:0] stat_v;

  assign avs_waitrequest_o = req & ~ack_q;
  assign stat_v = {1'b0, srq_on, addr_err_q, poll_q, talk_q, listen_q,
                   llo_q, rem_q};

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read_i & ~ack_q) begin
        case (avs_address_i)
          `OFS_ADDR: avs_readdata_o <= {27'h0, addr_q};
          `OFS_STAT: avs_readdata_o <= {24'h0, stat_v};
          `OFS_STB: avs_readdata_o <= {24'h0, stb_q};
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= `ADDR_FACTORY;
      addr_err_q <= 1'b0;
      stb_q <= `STB_RST;
    end else begin
      if (dflt_wr) begin
        addr_q <= `ADDR_FACTORY;
      end else if (addr_wr & addr_ok) begin
        addr_q <= avs_writedata_i[4:0];
      end
      if (addr_wr & ~addr_ok) begin
        addr_err_q <= 1'b1;
      end else if (rd_go & (avs_address_i == `OFS_STAT)) begin
        addr_err_q <= 1'b0;
      end
      if (wr_go & (avs_address_i == `OFS_STB)) begin
        stb_q <= avs_writedata_i[7:0];
      end
    end
  end

  // ==========================================
  // Acceptor handshake and message decode
  wire acc_on = (atn_i | listen_q) & ~ifc_i;
  wire take = acc_on & dav_i & ~hold_q;
  wire cmd_take = take & atn_i;
  wire dat_take = take & ~atn_i;
  wire [6:0] cmd = dio_i[6:0];
  wire my_listen = cmd == {`GRP_LISTEN, addr_q};
  wire my_talk = cmd == {`GRP_TALK, addr_q};
  wire other_talk = (cmd[6:5] == `GRP_TALK) & ~my_talk;
  wire is_gtl = cmd_take & (cmd == `MSG_GTL) & listen_q;
  wire is_get = cmd_take & (cmd == `MSG_GET) & listen_q;
  wire is_sdc = cmd_take & (cmd == `MSG_SDC) & listen_q;
  wire is_dcl = cmd_take & (cmd == `MSG_DCL);
  wire lkey_press = local_key_i & ~lkey_q;

  assign nrfd_o = 1'b1;
  assign ndac_o = 1'b1;
  assign nrfd_oe_n_o = ~(acc_on & hold_q);
  assign ndac_oe_n_o = ~(acc_on & ~hold_q);

  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      trigger_o <= 1'b0;
      dev_clear_o <= 1'b0;
    end else begin
      if (take) begin
        hold_q <= 1'b1;
      end else if (~dav_i | ~acc_on) begin
        hold_q <= 1'b0;
      end
      rx_valid_o <= dat_take;
      if (dat_take) begin
        rx_data_o <= dio_i;
      end
      trigger_o <= is_get;
      dev_clear_o <= is_dcl | is_sdc;
    end
  end

  // ==========================================
  // Addressing, remote and lockout; IFC clears addressing and remote but not lockout, and the handshake states hold_q and src_q
  always @(posedge clk_i) begin
    if (rst_i) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
      rem_q <= 1'b0;
      llo_q <= 1'b0;
      poll_q <= 1'b0;
      lkey_q <= 1'b0;
    end else begin
      lkey_q <= local_key_i;
      if (ifc_i) begin
        listen_q <= 1'b0;
        talk_q <= 1'b0;
        poll_q <= 1'b0;
      end else if (cmd_take) begin
        if (my_listen) begin
          listen_q <= 1'b1;
        end else if (cmd == `MSG_UNL) begin
          listen_q <= 1'b0;
        end
        if (my_talk) begin
          talk_q <= 1'b1;
        end else if ((cmd == `MSG_UNT) | other_talk) begin
          talk_q <= 1'b0;
        end
        if (cmd == `MSG_SPE) begin
          poll_q <= 1'b1;
        end else if (cmd == `MSG_SPD) begin
          poll_q <= 1'b0;
        end
      end
      if (~ren_i | ifc_i) begin
        rem_q <= 1'b0;
      end else if (cmd_take & my_listen) begin
        rem_q <= 1'b1;
      end else if (is_gtl) begin
        rem_q <= 1'b0;
      end else if (lkey_press & ~llo_q) begin
        rem_q <= 1'b0;
      end
      if (~ren_i | is_gtl) begin
        llo_q <= 1'b0;
      end else if (cmd_take & (cmd == `MSG_LLO)) begin
        llo_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Front panel gating and display
  assign keys_o = (rem_q | llo_q) ? {NKEY{1'b0}} : keys_i;
  assign remote_o = rem_q;
  assign addr_disp_o = addr_q;
  assign show_addr_o = show_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      show_q <= 1'b1;
    end else if ((|keys_i) | local_key_i) begin
      show_q <= 1'b0;
    end
  end

  // ==========================================
  // Source handshake: status byte in poll, else user data
  wire talk_on = talk_q & ~atn_i & ~ifc_i;
  wire load = talk_on & (src_q == `SRC_IDLE) & (poll_q | tx_valid_i);
  wire src_done = (src_q == `SRC_DAV) & ~ndac_i;

  assign tx_ready_o = talk_on & (src_q == `SRC_IDLE) & ~poll_q;
  assign dio_oe_n_o = ~(talk_on & (src_q != `SRC_IDLE) &
                        (src_q != `SRC_HOLD));
  assign dav_o = 1'b1;
  assign dav_oe_n_o = ~(talk_on & (src_q == `SRC_DAV));
  assign srq_o = 1'b1;
  assign srq_oe_n_o = ~srq_on;

  always @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= `SRC_IDLE;
      dio_o <= 8'h00;
      poll_byte_q <= 1'b0;
      polled_q <= 1'b0;
    end else begin
      if (~rsv) begin
        polled_q <= 1'b0;
      end else if (src_done & poll_byte_q & srq_on) begin
        polled_q <= 1'b1;
      end
      if (~talk_on) begin
        src_q <= `SRC_IDLE;
      end else begin
        case (src_q)
          `SRC_IDLE: begin
            if (load) begin
              src_q <= `SRC_WAIT;
              poll_byte_q <= poll_q;
              if (poll_q) begin
                dio_o <= {stb_q[7], srq_on, stb_q[5:0]};
              end else begin
                dio_o <= tx_data_i;
              end
            end
          end
          `SRC_WAIT: begin
            if (~nrfd_i) begin
              src_q <= `SRC_DAV;
            end
          end
          `SRC_DAV: begin
            if (~ndac_i) begin
              src_q <= poll_byte_q ? `SRC_HOLD : `SRC_IDLE;
            end
          end
          `SRC_HOLD: begin
            if (~poll_q) begin
              src_q <= `SRC_IDLE;
            end
          end
          default: src_q <= `SRC_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire
